/* dv/lmc_bus_model.sv */
// bus model: single wire bus with pull-up, another node and wake comparator
`timescale 1ns/1ns
module lmc_bus_model (
  input wire logic dut_low_i, // design pulls bus dominant
  input wire logic node_low_i, // other node pulls bus dominant
  output logic bus_line_o, // 1 = recessive
  output logic bus_wake_o // 1 = bus below wake threshold
);
  // ****************************************************************
  // wired level
  // ****************************************************************
  // pull-up keeps recessive unless any node pulls low
  assign bus_line_o = !(dut_low_i || node_low_i);
  // wake comparator trips on any dominant level
  assign bus_wake_o = !bus_line_o;
endmodule : lmc_bus_model

/* dv/lmc_mode_ctrl_tb.sv */
// self-checking bench of the transceiver mode controller
`timescale 1ns/1ns
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_total++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (a), (b)); end end
module lmc_mode_ctrl_tb;
  // ****************************************************************
  // stimulus and observed signals
  // ****************************************************************
  logic mclk_i = 0, rst_i = 1, ce_i = 1, rx_ready_i = 1, node_low = 0;
  logic sup_on = 0, sup_off = 0, reg_ok = 0, fault = 0, sel = 0, txd = 1;
  logic bus_lvl, bus_wk, rx_valid, rxd, bus_o, bus_oe, rst_o, rst_oe;
  logic [2:0] h = 3'h7; // recent transmit levels
  lmc_pkg::lmc_pins_t pins;
  lmc_pkg::lmc_ctl_t ctl;
  lmc_pkg::lmc_mode_t mode, mode_last = lmc_pkg::LMC_POR, exp_m; // exp_m: note taken off
  lmc_pkg::lmc_mode_t exp_q[$]; // expected mode changes, oldest first
  int err_total = 0, n_tests = 0, cyc = 0;
  logic [31:0] lfsr = 32'h0b4a;
  assign pins = {sup_on, sup_off, reg_ok, fault, sel, txd, bus_lvl, bus_wk};
  // small counts keep the run short
  lmc_mode_ctrl #(.DEGLITCH_CYC(4), .WAKE_DEBOUNCE_CYC(8), .DOM_TIMEOUT_CYC(16),
    .REG_SETTLE_CYC(8)) i_lmc_mode_ctrl (.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce_i),
    .pins_i(pins), .rx_ready_i(rx_ready_i), .rx_valid_o(rx_valid), .rxd_o(rxd),
    .bus_line_o(bus_o), .bus_line_oe_o(bus_oe), .reset_out_o(rst_o),
    .reset_out_oe_o(rst_oe), .ctl_o(ctl), .mode_o(mode));
  lmc_bus_model i_lmc_bus_model (.dut_low_i(bus_oe), .node_low_i(node_low),
    .bus_line_o(bus_lvl), .bus_wake_o(bus_wk));
  // 25 mhz clock
  always #20 mclk_i = ~mclk_i;
  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  // move to a fixed point after an edge
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
    #2;
  endtask : tick
  // note the expected mode, then wait for it, bounded
  task automatic go(input lmc_pkg::lmc_mode_t m);
    exp_q.push_back(m);
    for (int i = 0; i < 100 && mode !== m; i++)
    begin
      tick(1);
    end
  endtask : go
  task automatic results();
    err_total += exp_q.size(); // notes never met count as mismatches
    $display("counts: %0d compares, %0d mismatches", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : results
  // ****************************************************************
  // mode watcher and time limit
  // ****************************************************************
  always @(posedge mclk_i)
  begin
    cyc++;
    // every mode change takes the oldest note; a change with no note left counts as a mismatch
    if (!rst_i && mode !== mode_last)
    begin
      if (exp_q.size() == 0)
        `CHK(mode, mode_last)
      else
      begin
        exp_m = exp_q.pop_front();
        `CHK(mode, exp_m)
      end
      mode_last = mode;
    end
    // time limit ends the run last in this process
    if (cyc == 3000)
    begin
      err_total++;
      results();
    end
  end
  // ****************************************************************
  // scenarios
  // ****************************************************************
  initial
  begin
    tick(2);
    rst_i = 0;
    tick(1);
    `CHK(ctl, 5'h00)
    `CHK(rst_oe, 1'b1)
    `CHK(rst_o, 1'b0)
    `CHK(bus_o, 1'b0)
    sup_on = 1;
    go(lmc_pkg::LMC_READY);
    `CHK(ctl, 5'h0c)
    sel = 1;
    tick(12);
    `CHK(mode, lmc_pkg::LMC_READY)
    reg_ok = 1;
    tick(6);
    `CHK(mode, lmc_pkg::LMC_READY)
    go(lmc_pkg::LMC_OPER);
    `CHK(ctl, 5'h1e)
    `CHK(rst_oe, 1'b0)
    $display("done: power-up");
    // random transmit data, receiver stalls now and then
    for (int i = 0; i < 24; i++)
    begin
      lfsr = lfsr_next(lfsr);
      txd = lfsr[0] | (i % 8 == 7);
      rx_ready_i = lfsr[1];
      h = {h[1:0], txd};
      tick(1);
      if (i > 1)
        `CHK(bus_oe, !h[1])
    end
    txd = 0;
    rx_ready_i = 1;
    tick(8);
    `CHK(rxd, 1'b0)
    // receiver stalls: the change waits in the buffer
    txd = 1;
    rx_ready_i = 0;
    tick(8);
    `CHK(rx_valid, 1'b1)
    `CHK(rxd, 1'b0)
    rx_ready_i = 1;
    tick(2);
    `CHK(rxd, 1'b1)
    `CHK(rx_valid, 1'b0)
    // other node holds the bus dominant
    node_low = 1;
    tick(26);
    `CHK(ctl.tx_en, 1'b0)
    `CHK(ctl.pullup_en, 1'b0)
    `CHK(rxd, 1'b1)
    node_low = 0;
    tick(6);
    `CHK(ctl, 5'h1e)
    reg_ok = 0;
    tick(4);
    `CHK(ctl.tx_en, 1'b0)
    `CHK(rst_oe, 1'b1)
    reg_ok = 1;
    $display("done: operation");
    fault = 1;
    go(lmc_pkg::LMC_TXOFF);
    `CHK(ctl, 5'h0c)
    fault = 0;
    go(lmc_pkg::LMC_OPER);
    sel = 0;
    go(lmc_pkg::LMC_TXOFF);
    tick(10);
    `CHK(mode, lmc_pkg::LMC_TXOFF)
    sel = 1;
    go(lmc_pkg::LMC_OPER);
    txd = 0;
    tick(1);
    sel = 0;
    exp_q.push_back(lmc_pkg::LMC_TXOFF);
    go(lmc_pkg::LMC_PDOWN);
    `CHK(ctl, 5'h01)
    txd = 1;
    $display("done: power-down");
    // a short low must not wake
    node_low = 1;
    tick(5);
    node_low = 0;
    tick(6);
    `CHK(mode, lmc_pkg::LMC_PDOWN)
    // remote wake: long low, then release
    node_low = 1;
    tick(12);
    `CHK(mode, lmc_pkg::LMC_PDOWN)
    node_low = 0;
    go(lmc_pkg::LMC_READY);
    `CHK(ctl.reg_en, 1'b1)
    sup_off = 1;
    go(lmc_pkg::LMC_POR);
    `CHK(ctl, 5'h00)
    $display("done: wake and supply loss");
    tick(2);
    results();
  end
endmodule : lmc_mode_ctrl_tb

/* logic/lmc_buf2.sv */
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ns
module lmc_buf2 #(
  parameter int W = 1
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic in_valid_i,
  input wire logic [W-1:0] in_data_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output logic [W-1:0] out_data_o,
  input wire logic out_ready_i
);

  logic [W-1:0] head_r; // oldest entry
  logic [W-1:0] head_nxt;
  logic [W-1:0] tail_r; // second entry
  logic [W-1:0] tail_nxt;
  logic [1:0] cnt_r; // entries held, 0 to 2
  logic [1:0] cnt_nxt;
  logic push;
  logic pop;

  // ****************************************************************
  // next values
  // ****************************************************************
  always_comb
  begin
    push = in_valid_i && (cnt_r != 2'h2);
    pop = out_ready_i && (cnt_r != 2'h0);
    head_nxt = head_r;
    tail_nxt = tail_r;
    cnt_nxt = cnt_r;
    case ({push, pop})
      2'b10:
      begin
        if (cnt_r == 2'h0)
          head_nxt = in_data_i;
        else
          tail_nxt = in_data_i;
        cnt_nxt = cnt_r + 2'h1;
      end
      2'b01:
      begin
        head_nxt = tail_r;
        cnt_nxt = cnt_r - 2'h1;
      end
      2'b11:
      begin
        // one leaves, one arrives
        if (cnt_r == 2'h1)
          head_nxt = in_data_i;
        else
        begin
          head_nxt = tail_r;
          tail_nxt = in_data_i;
        end
      end
      default:
      begin
        cnt_nxt = cnt_r;
      end
    endcase
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      head_r <= '0;
      tail_r <= '0;
      cnt_r <= 2'h0;
    end
    else if (ce_i)
    begin
      head_r <= head_nxt;
      tail_r <= tail_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  assign in_ready_o = (cnt_r != 2'h2);
  assign out_valid_o = (cnt_r != 2'h0);
  assign out_data_o = head_r;

endmodule : lmc_buf2

/* logic/lmc_mode_ctrl.sv */
// mode controller of a single-wire bus transceiver with regulator
// Summary of operation
// [RL1] low battery or power-up forces reset mode
// [RL2] reset mode exits to ready above turn-on
// [RL3] reset mode: all off, reset pin low
// [RL4] ready: regulator and receiver on, transmitter off
// [RL5] ready held until regulator stable, select high
// [RL6] select high, regulator ok, transmit high: operate
// [RL7] ready, select high, transmit low: transmitter off
// [RL8] pull-up connected only in operation mode
// [RL9] select fall or fault leaves operation
// [RL10] transmit low at select fall: deglitched power-down
// [RL11] transmitter-off mode: receiver on, transmitter off
// [RL12] transmitter off while regulator unstable or faulted
// [RL13] transmitter-off, both pins low: power-down
// [RL14] transmitter-off, both pins high: operation
// [RL15] power-down: only wake detection stays on
// [RL16] bus wake or select high: ready
// [RL17] wait for regulator settle after wake-up
// [RL18] power-down uses wake threshold comparator only
// [RL19] wake needs debounced low then rising edge
// [RL20] transmitter drives bus low when transmit low
// [RL21] receive output follows bus when receiver on
// [RL22] dominant timeout kills driver, pull-up, receive
// [RL23] reset pin released while regulator ok
// [RL24] comparators and pins synchronised before use
// [RL25] delays counted with configurable terminal counts
`timescale 1ns/1ns
module lmc_mode_ctrl #(
  parameter int unsigned DEGLITCH_CYC = lmc_pkg::DEGLITCH_CYC,
  parameter int unsigned WAKE_DEBOUNCE_CYC = lmc_pkg::WAKE_DEBOUNCE_CYC,
  parameter int unsigned DOM_TIMEOUT_CYC = lmc_pkg::DOM_TIMEOUT_CYC,
  parameter int unsigned REG_SETTLE_CYC = lmc_pkg::REG_SETTLE_CYC
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire lmc_pkg::lmc_pins_t pins_i,
  input wire logic rx_ready_i,
  output logic rx_valid_o,
  output logic rxd_o,
  output logic bus_line_o,
  output logic bus_line_oe_o,
  output logic reset_out_o,
  output logic reset_out_oe_o,
  output lmc_pkg::lmc_ctl_t ctl_o,
  output lmc_pkg::lmc_mode_t mode_o
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  lmc_pkg::lmc_pins_t p; // synchronised inputs
  lmc_pkg::lmc_mode_t mode_r; // current mode
  lmc_pkg::lmc_mode_t mode_nxt;
  logic sel_prev_r; // select level one cycle ago
  logic sel_prev_nxt;
  logic sel_fall; // falling edge of select
  logic [lmc_pkg::CNT_W-1:0] dg_cnt_r; // power-down deglitch
  logic [lmc_pkg::CNT_W-1:0] dg_cnt_nxt;
  logic [lmc_pkg::CNT_W-1:0] st_cnt_r; // regulator settle
  logic [lmc_pkg::CNT_W-1:0] st_cnt_nxt;
  logic [lmc_pkg::CNT_W-1:0] wk_cnt_r; // wake debounce
  logic [lmc_pkg::CNT_W-1:0] wk_cnt_nxt;
  logic [lmc_pkg::CNT_W-1:0] to_cnt_r; // dominant timeout
  logic [lmc_pkg::CNT_W-1:0] to_cnt_nxt;
  logic wk_armed_r; // bus stayed low long enough
  logic wk_armed_nxt;
  logic dom_to_r; // dominant timeout tripped
  logic dom_to_nxt;
  logic reg_stable; // regulator ok and settled
  logic wake_event; // debounced bus wake
  logic rx_active; // receiver enabled and not timed out
  logic src_val; // level offered to the receive buffer
  logic last_r; // level last accepted by the buffer
  logic last_nxt;
  logic buf_in_ready;
  logic buf_out_valid;
  logic buf_out_data;
  logic rxd_r; // receive output register
  logic rxd_nxt;

  // ****************************************************************
  // input synchroniser
  // ****************************************************************
  // comparators and pins cross into the time base here [RL24]
  lmc_sync #(
    .W($bits(lmc_pkg::lmc_pins_t))
  ) u_sync (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .async_i(pins_i),
    .sync_o(p)
  );

  // ****************************************************************
  // timers
  // ****************************************************************
  // counters run on the time base to configurable terminal counts [RL25]
  always_comb
  begin
    sel_prev_nxt = p.select_wake_in;
    // deglitch only while both pins sit low in transmitter-off
    if ((mode_r == lmc_pkg::LMC_TXOFF) && !p.select_wake_in && !p.txd) // [RL10]
      dg_cnt_nxt = lmc_pkg::cnt_done(dg_cnt_r, DEGLITCH_CYC) ? dg_cnt_r : dg_cnt_r + 1'b1;
    else
      dg_cnt_nxt = lmc_pkg::CNT_RST;
    // settle time counted in ready while regulator is ok
    if ((mode_r == lmc_pkg::LMC_READY) && p.regulator_ok) // [RL17]
      st_cnt_nxt = lmc_pkg::cnt_done(st_cnt_r, REG_SETTLE_CYC) ? st_cnt_r : st_cnt_r + 1'b1;
    else
      st_cnt_nxt = lmc_pkg::CNT_RST;
    // wake comparator only, counted in power-down [RL18]
    if ((mode_r == lmc_pkg::LMC_PDOWN) && p.bus_wake)
      wk_cnt_nxt = lmc_pkg::cnt_done(wk_cnt_r, WAKE_DEBOUNCE_CYC) ? wk_cnt_r : wk_cnt_r + 1'b1;
    else
      wk_cnt_nxt = lmc_pkg::CNT_RST;
    // armed after a full debounce, dropped when low ends or mode changes
    wk_armed_nxt = (mode_r == lmc_pkg::LMC_PDOWN) && p.bus_wake &&
                   (wk_armed_r || lmc_pkg::cnt_done(wk_cnt_r, WAKE_DEBOUNCE_CYC)); // [RL19]
    // dominant timer, cleared by recessive or reset mode [RL22]
    if ((mode_r != lmc_pkg::LMC_POR) && !p.bus_line)
      to_cnt_nxt = lmc_pkg::cnt_done(to_cnt_r, DOM_TIMEOUT_CYC) ? to_cnt_r : to_cnt_r + 1'b1;
    else
      to_cnt_nxt = lmc_pkg::CNT_RST;
    dom_to_nxt = (mode_r != lmc_pkg::LMC_POR) && !p.bus_line &&
                 (dom_to_r || lmc_pkg::cnt_done(to_cnt_r, DOM_TIMEOUT_CYC)); // [RL22]
  end

  // debounced low followed by the rising edge [RL19]
  assign wake_event = wk_armed_r && !p.bus_wake;
  assign reg_stable = p.regulator_ok && lmc_pkg::cnt_done(st_cnt_r, REG_SETTLE_CYC); // [RL17]
  assign sel_fall = sel_prev_r && !p.select_wake_in;

  // timer registers
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      sel_prev_r <= 1'h0;
      dg_cnt_r <= lmc_pkg::CNT_RST;
      st_cnt_r <= lmc_pkg::CNT_RST;
      wk_cnt_r <= lmc_pkg::CNT_RST;
      to_cnt_r <= lmc_pkg::CNT_RST;
      wk_armed_r <= 1'h0;
      dom_to_r <= 1'h0;
    end
    else if (ce_i)
    begin
      sel_prev_r <= sel_prev_nxt;
      dg_cnt_r <= dg_cnt_nxt;
      st_cnt_r <= st_cnt_nxt;
      wk_cnt_r <= wk_cnt_nxt;
      to_cnt_r <= to_cnt_nxt;
      wk_armed_r <= wk_armed_nxt;
      dom_to_r <= dom_to_nxt;
    end
  end

  // ****************************************************************
  // mode state machine
  // ****************************************************************
  always_comb
  begin
    mode_nxt = mode_r;
    if (p.supply_below_off)
      mode_nxt = lmc_pkg::LMC_POR; // [RL1]
    else
    begin
      case (mode_r)
        lmc_pkg::LMC_POR:
        begin
          // wait for the turn-on threshold [RL2]
          if (p.supply_above_on)
            mode_nxt = lmc_pkg::LMC_READY;
        end
        lmc_pkg::LMC_READY:
        begin
          // held until settled and selected [RL5]
          if (reg_stable && p.select_wake_in)
            mode_nxt = p.txd ? lmc_pkg::LMC_OPER : lmc_pkg::LMC_TXOFF; // [RL6] [RL7]
        end
        lmc_pkg::LMC_OPER:
        begin
          // deselect or fault drops the transmitter [RL9]
          if (sel_fall || p.fault)
            mode_nxt = lmc_pkg::LMC_TXOFF;
        end
        lmc_pkg::LMC_TXOFF:
        begin
          if (lmc_pkg::cnt_done(dg_cnt_r, DEGLITCH_CYC))
            mode_nxt = lmc_pkg::LMC_PDOWN; // [RL13] [RL10]
          else if (p.select_wake_in && p.txd && p.regulator_ok && !p.fault)
            mode_nxt = lmc_pkg::LMC_OPER; // [RL14] [RL6]
        end
        lmc_pkg::LMC_PDOWN:
        begin
          // remote or local wake-up [RL16]
          if (wake_event || p.select_wake_in)
            mode_nxt = lmc_pkg::LMC_READY;
        end
        default:
        begin
          mode_nxt = lmc_pkg::LMC_POR;
        end
      endcase
    end
  end

  // mode register, reset mode on power-up [RL1]
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      mode_r <= lmc_pkg::LMC_POR;
    else if (ce_i)
      mode_r <= mode_nxt;
  end

  // ****************************************************************
  // enables and pins
  // ****************************************************************
  always_comb
  begin
    // transmitter only in operation, regulator good, no fault [RL12] [RL22]
    ctl_o.tx_en = (mode_r == lmc_pkg::LMC_OPER) && p.regulator_ok && !p.fault && !dom_to_r;
    // receiver in ready, operation and transmitter-off [RL4] [RL11]
    ctl_o.rx_en = (mode_r == lmc_pkg::LMC_READY) || (mode_r == lmc_pkg::LMC_OPER) ||
                  (mode_r == lmc_pkg::LMC_TXOFF);
    // regulator off in reset mode and power-down [RL3] [RL15]
    ctl_o.reg_en = ctl_o.rx_en;
    ctl_o.pullup_en = (mode_r == lmc_pkg::LMC_OPER) && !dom_to_r; // [RL8] [RL22]
    ctl_o.wake_en = (mode_r == lmc_pkg::LMC_PDOWN); // [RL15]
  end

  // open drain bus: pull low while transmit is low [RL20]
  assign bus_line_o = 1'h0;
  assign bus_line_oe_o = ctl_o.tx_en && !p.txd; // [RL20]
  // open drain reset: released only with a good regulator [RL23] [RL3]
  assign reset_out_o = 1'h0;
  assign reset_out_oe_o = (mode_r == lmc_pkg::LMC_POR) || !p.regulator_ok; // [RL23] [RL3]
  assign mode_o = mode_r;

  // ****************************************************************
  // receive path
  // ****************************************************************
  // forced recessive when off or timed out [RL21] [RL22]
  assign rx_active = ctl_o.rx_en && !dom_to_r;
  assign src_val = rx_active ? p.bus_line : lmc_pkg::RXD_RST;

  // every level change is offered; held while the buffer is full
  lmc_buf2 #(
    .W(1)
  ) u_buf (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .in_valid_i(src_val != last_r),
    .in_data_i(src_val),
    .in_ready_o(buf_in_ready),
    .out_valid_o(buf_out_valid),
    .out_data_o(buf_out_data),
    .out_ready_i(rx_ready_i)
  );

  // next values of the receive path
  always_comb
  begin
    last_nxt = (buf_in_ready && (src_val != last_r)) ? src_val : last_r;
    rxd_nxt = (buf_out_valid && rx_ready_i) ? buf_out_data : rxd_r; // [RL21]
  end

  // receive registers
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      last_r <= lmc_pkg::RXD_RST;
      rxd_r <= lmc_pkg::RXD_RST;
    end
    else if (ce_i)
    begin
      last_r <= last_nxt;
      rxd_r <= rxd_nxt;
    end
  end

  assign rxd_o = rxd_r;
  assign rx_valid_o = buf_out_valid;

  // ****************************************************************
  // assertions
  // ****************************************************************
  sequence s_sel_fall;
    ce_i && sel_fall && !p.supply_below_off;
  endsequence
  sequence s_both_low;
    ce_i && (mode_r == lmc_pkg::LMC_TXOFF) && !p.select_wake_in && !p.txd;
  endsequence
  AST_SUPPLY_LOW: assert property (@(posedge mclk_i) disable iff (rst_i) // [RL1]
    ce_i && p.supply_below_off |=> mode_r == lmc_pkg::LMC_POR)
    else $error("low supply did not force reset mode");
  AST_POR_EXIT: assert property (@(posedge mclk_i) disable iff (rst_i) // [RL2]
    ce_i && (mode_r == lmc_pkg::LMC_POR) && p.supply_above_on && !p.supply_below_off
    |=> mode_r == lmc_pkg::LMC_READY)
    else $error("reset mode did not exit to ready");
  AST_POR_OUTPUTS: assert property (@(posedge mclk_i) disable iff (rst_i) // [RL3]
    mode_r == lmc_pkg::LMC_POR |-> !ctl_o.tx_en && !ctl_o.rx_en && !ctl_o.reg_en &&
    reset_out_oe_o)
    else $error("reset mode outputs wrong");
  AST_READY_EN: assert property (@(posedge mclk_i) disable iff (rst_i) // [RL4]
    mode_r == lmc_pkg::LMC_READY |-> ctl_o.reg_en && ctl_o.rx_en && !bus_line_oe_o)
    else $error("ready mode enables wrong");
  AST_READY_HOLD: assert property (@(posedge mclk_i) disable iff (rst_i) // [RL5]
    ce_i && (mode_r == lmc_pkg::LMC_READY) && !p.supply_below_off &&
    !(reg_stable && p.select_wake_in) |=> mode_r == lmc_pkg::LMC_READY)
    else $error("ready left too early");
  AST_OPER_EXIT: assert property (@(posedge mclk_i) disable iff (rst_i) // [RL9]
    (mode_r == lmc_pkg::LMC_OPER) ##0 s_sel_fall |=> mode_r == lmc_pkg::LMC_TXOFF)
    else $error("select fall did not leave operation");
  // the deglitch counter saturates at its terminal count
  AST_PDOWN_DELAY: assert property (@(posedge mclk_i) disable iff (rst_i) // [RL10]
    ce_i && (mode_r == lmc_pkg::LMC_PDOWN) && ($past(mode_r) == lmc_pkg::LMC_TXOFF)
    |-> $past(dg_cnt_r) == (DEGLITCH_CYC - 1))
    else $error("power-down entered without full deglitch");
  AST_PDOWN_GO: assert property (@(posedge mclk_i) disable iff (rst_i) // [RL13]
    s_both_low ##0 (ce_i && lmc_pkg::cnt_done(dg_cnt_r, DEGLITCH_CYC) && !p.supply_below_off)
    |=> mode_r == lmc_pkg::LMC_PDOWN)
    else $error("both pins low did not reach power-down");
  AST_TX_UNSTABLE: assert property (@(posedge mclk_i) disable iff (rst_i) // [RL12]
    !p.regulator_ok || p.fault |-> !bus_line_oe_o)
    else $error("transmitter active with bad regulator");
  AST_WAKE: assert property (@(posedge mclk_i) disable iff (rst_i) // [RL16]
    ce_i && (mode_r == lmc_pkg::LMC_PDOWN) && (p.select_wake_in || wake_event) &&
    !p.supply_below_off |=> (mode_r == lmc_pkg::LMC_READY) && ctl_o.reg_en)
    else $error("wake did not reach ready");
  AST_PULLUP: assert property (@(posedge mclk_i) disable iff (rst_i) // [RL8]
    ctl_o.pullup_en |-> (mode_r == lmc_pkg::LMC_OPER))
    else $error("pull-up connected outside operation");

endmodule : lmc_mode_ctrl

/* logic/lmc_pkg.sv */
// shared constants, types and helpers of the transceiver mode controller
package lmc_pkg;

  // ****************************************************************
  // clock and timing
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_NS = 40; // 25 mhz time base
  localparam int unsigned DEGLITCH_NS = 20_000; // power-down deglitch
  localparam int unsigned WAKE_DEBOUNCE_NS = 80_000; // bus wake low time
  localparam int unsigned DOM_TIMEOUT_NS = 20_000_000; // dominant timeout
  localparam int unsigned REG_SETTLE_NS = 300_000; // regulator settle, least
  // least times round up to whole cycles
  localparam int unsigned DEGLITCH_CYC = (DEGLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WAKE_DEBOUNCE_CYC =
    (WAKE_DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DOM_TIMEOUT_CYC = DOM_TIMEOUT_NS / CLK_PERIOD_NS;
  localparam int unsigned REG_SETTLE_CYC = (REG_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W = 20; // wide enough for every count

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic RXD_RST = 1'h1; // receive output idles recessive
  localparam logic [CNT_W-1:0] CNT_RST = 20'h00000;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [2:0] {
    LMC_POR,
    LMC_READY,
    LMC_OPER,
    LMC_TXOFF,
    LMC_PDOWN
  } lmc_mode_t;

  // comparator results and pins, as they enter the synchroniser
  typedef struct packed {
    logic supply_above_on; // battery_supply above supply_on_threshold
    logic supply_below_off; // battery_supply below supply_off_threshold
    logic regulator_ok; // regulator_out above 0.8 of regulator_nominal
    logic fault; // thermal or overload fault
    logic select_wake_in; // select and local wake pin
    logic txd; // transmit data pin
    logic bus_line; // normal receive comparator, 1 = recessive
    logic bus_wake; // 1 = bus_line below bus_wake_threshold
  } lmc_pins_t;

  // enables to the analog sections
  typedef struct packed {
    logic tx_en; // bus transmitter
    logic rx_en; // receiver
    logic reg_en; // regulator
    logic pullup_en; // termination pull-up to battery
    logic wake_en; // bus wake detector
  } lmc_ctl_t;

  // ****************************************************************
  // helpers
  // ****************************************************************
  // true once a counter has reached its terminal count
  function automatic logic cnt_done(input logic [CNT_W-1:0] c, input int unsigned t);
    cnt_done = c >= CNT_W'(t - 1);
  endfunction : cnt_done

endpackage : lmc_pkg

/* logic/lmc_sync.sv */
// two flip-flop synchroniser for a group of asynchronous inputs
`timescale 1ns/1ns
module lmc_sync #(
  parameter int W = 8
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);

  logic [W-1:0] meta_r; // first stage, read only by the second
  logic [W-1:0] meta_nxt;
  logic [W-1:0] sync_r; // second stage
  logic [W-1:0] sync_nxt;

  // ****************************************************************
  // next values
  // ****************************************************************
  always_comb
  begin
    meta_nxt = async_i;
    sync_nxt = meta_r;
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      meta_r <= '0;
      sync_r <= '0;
    end
    else if (ce_i)
    begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign sync_o = sync_r;

endmodule : lmc_sync
